//--- common/ffmd_pkg.sv
/*
 * Types shared by the free-fall / motion detector.
 * Assumes ffmd_regs.svh is on the include path.
 */
package ffmd_pkg;
   `include "ffmd_regs.svh"

   // One three-axis sample, two's complement
   typedef struct packed {
      logic signed [13:0] z;
      logic signed [13:0] y;
      logic signed [13:0] x;
   } ffmd_sample_t;

   // Register access request from the serial host front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ffmd_req_t;

   // Whole state of the detector
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] ths;
      logic [7:0] dbc;
      logic xyz_en;
      logic [2:0][12:0] th;
      logic ien;
      logic route;
      logic [7:0] cnt;
      logic det;
      logic ea;
      logic [5:0] flags;
      logic [7:0] rdata;
      logic int1;
      logic int2;
   } ffmd_state_t;
endpackage

//--- common/ffmd_regs.svh
/*
 * Register map, field positions, reset values and sizes of the
 * free-fall / motion detector.
 * Assumes it is included by bare name from the package and the RTL.
 */
`ifndef FFMD_REGS_SVH
`define FFMD_REGS_SVH

// Register offsets
`define FFMD_CFG_ADDR 8'h15
`define FFMD_SRC_ADDR 8'h16
`define FFMD_THS_ADDR 8'h17
`define FFMD_CNT_ADDR 8'h18
`define FFMD_IEN_ADDR 8'h20
`define FFMD_IRT_ADDR 8'h21
`define FFMD_THX_MSB_ADDR 8'h73
`define FFMD_THX_LSB_ADDR 8'h74
`define FFMD_THY_MSB_ADDR 8'h75
`define FFMD_THY_LSB_ADDR 8'h76
`define FFMD_THZ_MSB_ADDR 8'h77
`define FFMD_THZ_LSB_ADDR 8'h78

// Configuration register fields
`define FFMD_CFG_LATCH_BIT 7
`define FFMD_CFG_OR_BIT 6
`define FFMD_CFG_EN_HI 5
`define FFMD_CFG_EN_LO 3
`define FFMD_CFG_RESET 8'h00

// Source register fields
`define FFMD_SRC_EA_BIT 7

// Common threshold register fields
`define FFMD_THS_DBCNTM_BIT 7
`define FFMD_THS_RESET 8'h00

// Per-axis threshold MSB register fields
`define FFMD_THM_XYZ_EN_BIT 7
`define FFMD_THM_VAL_HI 4

// Interrupt enable and routing bit positions
`define FFMD_IEN_BIT 2
`define FFMD_IRT_BIT 2

// Reset values of other registers
`define FFMD_CNT_RESET 8'h00
`define FFMD_TH13_RESET 13'h0000

`endif

//--- rtl/ffmd_detector.sv
/*
 * Free-fall / motion detector with its register set.
 * Assumes register requests and samples come from logic on i_clock,
 * one request per cycle, and one sample per output-data-rate tick.
 */
`timescale 1ns/1ps
`include "ffmd_regs.svh"

//Contract
//- Low-g mode: event only when every enabled axis is low-g.
//- High-g mode: event when any enabled axis is high-g.
//- Common threshold at 17h, per-axis thresholds at 73h to 78h.
//- Latch on: event held; flag cleared only by source register read.
//- Latch off: event flag follows current detection result.
//- Debounce mode bit lives in common threshold register.
//- Axis takes part only when its enable bit is set.
//- Per-axis off: all axes compared with 7-bit common threshold.
//- Per-axis on: each axis compared with its own 13-bit threshold.
//- Config 15h: latch b7, combine b6, Z/Y/X enables b5..b3, reset 0.
//- Latch on: axis and polarity flags frozen while event flag set.
//- Source 16h: event b7, Z/Y/X event and negative-polarity pairs b5..b0.
//- Event flag, interrupt enable and routing make the interrupt outputs.
module ffmd_detector
   import ffmd_pkg::*;
#(
   parameter int COMMON_SHIFT = 6
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire ffmd_req_t i_req,
   input wire logic i_sample_valid,
   input wire ffmd_sample_t i_sample,
   output logic [7:0] o_reg_rdata,
   output logic o_int1,
   output logic o_int2
);

   ffmd_state_t st_ff;
   ffmd_state_t nxt_st;
   logic [2:0][13:0] mag;
   logic [2:0][13:0] thr;
   logic [2:0] en;
   logic [2:0] hi;
   logic [2:0] axis_ev;
   logic [5:0] new_flags;
   logic cond;
   logic src_rd;
   logic ea_kept;
   logic [7:0] cnt_step;

   // Magnitude of a two's complement axis value; -8192 fits unsigned
   function automatic logic [13:0] abs14(input logic signed [13:0] v);
      abs14 = v[13] ? 14'(-v) : 14'(v);
   endfunction

   assign en = st_ff.cfg[`FFMD_CFG_EN_HI:`FFMD_CFG_EN_LO];
   assign src_rd = i_req.rd && (i_req.addr == `FFMD_SRC_ADDR);

   // Per-axis magnitude and threshold selection
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++) begin : g_axis
         logic signed [13:0] raw;
         if (ax == 0) begin : g_x
            assign raw = i_sample.x;
         end else if (ax == 1) begin : g_y
            assign raw = i_sample.y;
         end else begin : g_z
            assign raw = i_sample.z;
         end
         assign mag[ax] = abs14(raw);
         // Common 7-bit value is scaled up to the sample's step size
         assign thr[ax] = st_ff.xyz_en ? {1'b0, st_ff.th[ax]}
            : 14'({7'h00, st_ff.ths[6:0]} << COMMON_SHIFT);
         assign hi[ax] = mag[ax] > thr[ax];
         // Event per axis in the sense of the combine mode
         assign axis_ev[ax] = en[ax] && (st_ff.cfg[`FFMD_CFG_OR_BIT] ? hi[ax] : !hi[ax]);
         assign new_flags[2 * ax + 1] = axis_ev[ax];
         assign new_flags[2 * ax] = axis_ev[ax] && raw[13];
      end
   endgenerate

   // No enabled axis means no free-fall, avoiding a vacuous AND
   assign cond = st_ff.cfg[`FFMD_CFG_OR_BIT] ? (|axis_ev)
      : ((|en) && (axis_ev == en));

   // Debounce counter saturates at the programmed count
   assign cnt_step = (st_ff.cnt >= st_ff.dbc) ? st_ff.cnt : 8'(st_ff.cnt + 8'h01);
   assign ea_kept = src_rd ? 1'b0 : st_ff.ea;

   // Next-state computation for the whole block
   always_comb begin
      nxt_st = st_ff;
      // Register writes
      if (i_req.wr) begin
         unique case (i_req.addr)
            `FFMD_CFG_ADDR: nxt_st.cfg = {i_req.wdata[7:3], 3'h0};
            `FFMD_THS_ADDR: nxt_st.ths = i_req.wdata;
            `FFMD_CNT_ADDR: nxt_st.dbc = i_req.wdata;
            `FFMD_IEN_ADDR: nxt_st.ien = i_req.wdata[`FFMD_IEN_BIT];
            `FFMD_IRT_ADDR: nxt_st.route = i_req.wdata[`FFMD_IRT_BIT];
            `FFMD_THX_MSB_ADDR: begin
               nxt_st.xyz_en = i_req.wdata[`FFMD_THM_XYZ_EN_BIT];
               nxt_st.th[0][12:8] = i_req.wdata[`FFMD_THM_VAL_HI:0];
            end
            `FFMD_THX_LSB_ADDR: nxt_st.th[0][7:0] = i_req.wdata;
            `FFMD_THY_MSB_ADDR: nxt_st.th[1][12:8] = i_req.wdata[`FFMD_THM_VAL_HI:0];
            `FFMD_THY_LSB_ADDR: nxt_st.th[1][7:0] = i_req.wdata;
            `FFMD_THZ_MSB_ADDR: nxt_st.th[2][12:8] = i_req.wdata[`FFMD_THM_VAL_HI:0];
            `FFMD_THZ_LSB_ADDR: nxt_st.th[2][7:0] = i_req.wdata;
            default: ;
         endcase
      end
      // Debounce and detection, once per sample
      if (i_sample_valid) begin
         if (cond) begin
            nxt_st.cnt = cnt_step;
         end else if (st_ff.ths[`FFMD_THS_DBCNTM_BIT]) begin
            nxt_st.cnt = 8'h00;
         end else if (st_ff.cnt != 8'h00) begin
            nxt_st.cnt = 8'(st_ff.cnt - 8'h01);
         end
         nxt_st.det = cond && (nxt_st.cnt >= st_ff.dbc);
      end
      // Event flag and axis flags
      if (st_ff.cfg[`FFMD_CFG_LATCH_BIT]) begin
         nxt_st.ea = ea_kept;
         if (src_rd) begin
            nxt_st.flags = 6'h00;
         end
         // Flags track until the event sets, then freeze; a set beats a read
         if (i_sample_valid && !ea_kept) begin
            nxt_st.flags = new_flags;
         end
         if (i_sample_valid && nxt_st.det) begin
            nxt_st.ea = 1'b1;
         end
      end else if (i_sample_valid) begin
         nxt_st.ea = nxt_st.det;
         nxt_st.flags = new_flags;
      end
      // Read data, returned one cycle after the request
      if (i_req.rd) begin
         unique case (i_req.addr)
            `FFMD_CFG_ADDR: nxt_st.rdata = st_ff.cfg;
            // Disabled axes read zero even when frozen flags remain
            `FFMD_SRC_ADDR: nxt_st.rdata = {st_ff.ea, 1'b0, st_ff.flags & {en[2], en[2], en[1], en[1], en[0], en[0]}};
            `FFMD_THS_ADDR: nxt_st.rdata = st_ff.ths;
            `FFMD_CNT_ADDR: nxt_st.rdata = st_ff.dbc;
            `FFMD_IEN_ADDR: nxt_st.rdata = 8'(st_ff.ien) << `FFMD_IEN_BIT;
            `FFMD_IRT_ADDR: nxt_st.rdata = 8'(st_ff.route) << `FFMD_IRT_BIT;
            `FFMD_THX_MSB_ADDR: nxt_st.rdata = {st_ff.xyz_en, 2'h0, st_ff.th[0][12:8]};
            `FFMD_THX_LSB_ADDR: nxt_st.rdata = st_ff.th[0][7:0];
            `FFMD_THY_MSB_ADDR: nxt_st.rdata = {3'h0, st_ff.th[1][12:8]};
            `FFMD_THY_LSB_ADDR: nxt_st.rdata = st_ff.th[1][7:0];
            `FFMD_THZ_MSB_ADDR: nxt_st.rdata = {3'h0, st_ff.th[2][12:8]};
            `FFMD_THZ_LSB_ADDR: nxt_st.rdata = st_ff.th[2][7:0];
            default: nxt_st.rdata = 8'h00;
         endcase
      end
      // Interrupt pins from the next event flag so they match it in time
      nxt_st.int1 = nxt_st.ien && nxt_st.ea && nxt_st.route;
      nxt_st.int2 = nxt_st.ien && nxt_st.ea && !nxt_st.route;
   end

   // State register
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_reg_rdata = st_ff.rdata;
   assign o_int1 = st_ff.int1;
   assign o_int2 = st_ff.int2;

   // Checks on detection, latching and the register view
   chk_and_mode_miss: assert property (@(posedge i_clock) disable iff (i_reset)
      i_sample_valid && !st_ff.cfg[`FFMD_CFG_OR_BIT] && !cond |=> !st_ff.det)
      else $error("low-g mode detected without all enabled axes low");

   chk_or_mode_hit: assert property (@(posedge i_clock) disable iff (i_reset)
      i_sample_valid && st_ff.cfg[`FFMD_CFG_OR_BIT] && (|axis_ev) && st_ff.dbc == 8'h00 |=> st_ff.det)
      else $error("high-g axis event missed with zero debounce");

   chk_latch_hold: assert property (@(posedge i_clock) disable iff (i_reset)
      st_ff.cfg[`FFMD_CFG_LATCH_BIT] && st_ff.ea && !src_rd && !i_req.wr |=> st_ff.ea)
      else $error("latched event flag dropped without a source read");

   chk_realtime_follow: assert property (@(posedge i_clock) disable iff (i_reset)
      i_sample_valid && !st_ff.cfg[`FFMD_CFG_LATCH_BIT] && !i_req.wr |=> st_ff.ea == st_ff.det)
      else $error("real-time event flag differs from detection");

   chk_flags_frozen: assert property (@(posedge i_clock) disable iff (i_reset)
      st_ff.cfg[`FFMD_CFG_LATCH_BIT] && st_ff.ea && !src_rd && !i_req.wr |=> $stable(st_ff.flags))
      else $error("axis flags changed while latched event is set");

   chk_src_view: assert property (@(posedge i_clock) disable iff (i_reset)
      src_rd |=> o_reg_rdata[6] == 1'b0 && o_reg_rdata[`FFMD_SRC_EA_BIT] == $past(st_ff.ea))
      else $error("source read does not show the event flag");

   chk_int_pins: assert property (@(posedge i_clock) disable iff (i_reset)
      ##1 (o_int1 || o_int2) |-> st_ff.ea && st_ff.ien && (o_int1 != o_int2) && (o_int1 == st_ff.route))
      else $error("interrupt pin does not match event, enable and routing");

   chk_debounce_clear: assert property (@(posedge i_clock) disable iff (i_reset)
      i_sample_valid && !cond && st_ff.ths[`FFMD_THS_DBCNTM_BIT] && !i_req.wr |=> st_ff.cnt == 8'h00)
      else $error("debounce counter not cleared in clear mode");

   chk_axis_disabled: assert property (@(posedge i_clock) disable iff (i_reset)
      i_sample_valid && !en[0] && !st_ff.cfg[`FFMD_CFG_LATCH_BIT] && !i_req.wr |=> st_ff.flags[1:0] == 2'h0)
      else $error("disabled X axis raised a flag");

   chk_pol_needs_event: assert property (@(posedge i_clock) disable iff (i_reset)
      i_sample_valid && !st_ff.cfg[`FFMD_CFG_LATCH_BIT] && !i_req.wr |=> !st_ff.flags[0] || st_ff.flags[1])
      else $error("X polarity flag set without an X event");

endmodule

//--- testbench/ffmd_detector_tb_top.sv
/*
 * Self-checking bench: reads of source and config are checked with pins.
 * Assumes the detector, its package and the host model are compiled first.
 */
`timescale 1ns/1ps
`define CMP(e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH src_int exp %h got %h", e, g); end end
module ffmd_detector_tb_top;
   import ffmd_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic smp_v = 1'b0;
   ffmd_sample_t smp_d = '0;
   ffmd_req_t req;
   logic [7:0] rdata;
   logic int1;
   logic int2;
   logic [9:0] notes[$];
   logic [9:0] note;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'hC979;
   int mismatches = 0;
   int checked = 0;
   int v[3];
   int dseq[5] = '{100, 100, 10, 100, 100};

   initial begin
      forever #2.5 i_clock = ~i_clock;
   end

   ffmd_host_model host_u (.i_clock(i_clock), .o_req(req));
   ffmd_detector dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_req(req), .i_sample_valid(smp_v),
      .i_sample(smp_d), .o_reg_rdata(rdata), .o_int1(int1), .o_int2(int2));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.access(1'b1, a, d);
   endtask

   // Expected {int1, int2, read data} is noted before the read goes out
   task automatic rd(input logic [7:0] a, input logic [9:0] e);
      notes.push_back(e);
      host_u.access(1'b0, a, 8'h00);
   endtask

   // One sample strobe, then a spare cycle so the flag has settled
   task automatic smp(input int x, input int y, input int z);
      @(posedge i_clock);
      #1 smp_v = 1'b1;
      smp_d = '{z: 14'(z), y: 14'(y), x: 14'(x)};
      @(posedge i_clock);
      #1 smp_v = 1'b0;
      smp_d = ~smp_d;
      @(posedge i_clock);
   endtask

   task automatic tally_and_finish;
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Read data lands one edge after the strobe; pins checked alongside
   always @(posedge i_clock) begin
      if (rd_pend) begin
         note = notes.pop_front();
         `CMP(note, {int1, int2, rdata})
      end
      rd_pend <= req.rd;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clock);
      mismatches++;
      tally_and_finish;
   end

   initial begin
      repeat (2) @(posedge i_clock);
      #1 i_reset = 1'b0;
      rd(8'h15, 10'h000);
      wr(8'h20, 8'h04);
      wr(8'h21, 8'h04);
      wr(8'h15, 8'hFF);
      rd(8'h15, 10'h0F8);
      rd(8'h30, 10'h000);
      wr(8'h16, 8'hFF);
      rd(8'h16, 10'h000);
      wr(8'h17, 8'h01);
      wr(8'h15, 8'h48);
      smp(100, 0, 0);
      rd(8'h16, 10'h282);
      smp(-100, 0, 0);
      rd(8'h16, 10'h283);
      smp(10, 0, 1000);
      rd(8'h16, 10'h000);
      wr(8'h21, 8'h00);
      wr(8'h15, 8'h60);
      smp(0, 0, -100);
      rd(8'h16, 10'h1B0);
      smp(0, 0, 0);
      wr(8'h15, 8'hC8);
      smp(100, 0, 0);
      smp(-100, 0, 0);
      smp(10, 0, 0);
      rd(8'h16, 10'h082);
      smp(10, 0, 0);
      rd(8'h16, 10'h000);
      wr(8'h15, 8'h38);
      // Random sub-threshold axes in low-g mode
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         for (int k = 0; k < 3; k++)
            v[k] = seed[20 + k] ? -int'(seed[6 * k +: 6]) : int'(seed[6 * k +: 6]);
         smp(v[0], v[1], v[2]);
         rd(8'h16, {4'h6, 1'b1, v[2] < 0, 1'b1, v[1] < 0, 1'b1, v[0] < 0});
      end
      smp(10, 10, 1000);
      rd(8'h16, 10'h00A);
      wr(8'h15, 8'h48);
      wr(8'h73, 8'h81);
      wr(8'h74, 8'h2C);
      smp(300, 0, 0);
      rd(8'h16, 10'h000);
      smp(301, 0, 0);
      rd(8'h16, 10'h182);
      wr(8'h73, 8'h01);
      smp(200, 0, 0);
      rd(8'h16, 10'h182);
      // Interrupt enable off: event still readable, pins quiet
      wr(8'h20, 8'h00);
      rd(8'h16, 10'h082);
      wr(8'h20, 8'h04);
      wr(8'h18, 8'h03);
      foreach (dseq[i]) smp(dseq[i], 0, 0);
      rd(8'h16, 10'h182);
      wr(8'h17, 8'h81);
      smp(10, 0, 0);
      foreach (dseq[i]) smp(dseq[i], 0, 0);
      rd(8'h16, 10'h002);
      // Reset again mid-run: registers must return to zero
      @(posedge i_clock);
      #1 i_reset = 1'b1;
      repeat (2) @(posedge i_clock);
      #1 i_reset = 1'b0;
      rd(8'h15, 10'h000);
      rd(8'h18, 10'h000);
      repeat (3) @(posedge i_clock);
      if (notes.size() != 0)
         mismatches++;
      tally_and_finish;
   end
endmodule

//--- testbench/ffmd_host_model.sv
/*
 * Host model: issues register writes and reads to the detector.
 * Assumes one clock; each access is a one-cycle strobe after an edge.
 */
`timescale 1ns/1ps
module ffmd_host_model
   import ffmd_pkg::*;
(
   input wire logic i_clock,
   output ffmd_req_t o_req
);
   initial o_req = '0;
   // One strobe cycle, then idle; released lines are inverted, not held
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      #1 o_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_clock);
      #1 o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule
